// file: logic/scs_defs.vh
`ifndef SCS_DEFS_VH
`define SCS_DEFS_VH

// Register byte offsets
`define SCS_OFS_SYS_CTRL     8'h00
`define SCS_OFS_PLL_CTRL     8'h04
`define SCS_OFS_PRESCALER    8'h08
`define SCS_OFS_FLASH_CTRL   8'h0c
`define SCS_OFS_STATUS       8'h10

// Clock source select codes
`define SCS_SEL_WAKEUP       2'h0
`define SCS_SEL_PLL_PRESC    2'h2
`define SCS_SEL_DIRECT       2'h3

// Field positions
`define SCS_SYS_SEL_HI       1
`define SCS_SYS_SEL_LO       0
`define SCS_PLL_BYP_BIT      0
`define SCS_PLL_INT_BIT      1
`define SCS_PLL_P_HI         7
`define SCS_PLL_P_LO         4
`define SCS_PLL_N_HI         14
`define SCS_PLL_N_LO         8
`define SCS_PLL_K2_HI        22
`define SCS_PLL_K2_LO        16
`define SCS_PLL_WMASK        32'h007f_7ff3
`define SCS_PRE_HI           9
`define SCS_PRE_LO           0
`define SCS_FWS_HI           3
`define SCS_FWS_LO           0
`define SCS_ST_SEL_LO        0
`define SCS_ST_BYP_BIT       2
`define SCS_ST_PEND_BIT      3
`define SCS_ST_CLK_BIT       4
`define SCS_ST_PK_LO         16

// Reset values
`define SCS_RST_SEL          2'h0
`define SCS_RST_PLL_CTRL     32'h0000_0001
`define SCS_RST_PRESCALER    10'h000
`define SCS_RST_FWS          4'h4

`endif

// file: logic/scs_clock_select.v
`include "scs_defs.vh"
`default_nettype none

module scs_clock_select #(
  parameter AW = 16,
  parameter DW = 32
) (
  input  wire          clk_sys,
  input  wire          rst_n,
  input  wire [7:0]    avs_address,
  input  wire          avs_read,
  input  wire          avs_write,
  input  wire [31:0]   avs_writedata,
  input  wire [3:0]    avs_byteenable,
  output reg  [31:0]   avs_readdata,
  output reg           avs_waitrequest,
  input  wire          direct_clock_input,
  input  wire          crystal_input,
  input  wire          internal_clock_input,
  input  wire          wakeup_clock_input,
  input  wire          pll_vco_input,
  output reg           sys_clock_out,
  input  wire          fetch_req,
  input  wire [AW-1:0] fetch_addr,
  output reg           fetch_busy,
  output reg           fetch_valid,
  output reg  [DW-1:0] fetch_data,
  output reg  [AW-1:0] flash_addr,
  input  wire [DW-1:0] flash_rdata
);

  localparam ST_IDLE   = 2'h0;
  localparam ST_DEMAND = 2'h1;
  localparam ST_PREF   = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg  [1:0]    clock_source_select;
  reg  [31:0]   pll_control_reg0;
  reg  [9:0]    prescaler_divider_field;
  reg  [3:0]    flash_wait_state_count;
  wire          vco_bypass_bit = pll_control_reg0[`SCS_PLL_BYP_BIT];
  wire [3:0]    pll_input_divider_field = pll_control_reg0[`SCS_PLL_P_HI:`SCS_PLL_P_LO];
  wire [6:0]    pll_multiplier_field = pll_control_reg0[`SCS_PLL_N_HI:`SCS_PLL_N_LO];
  wire [6:0]    pll_output_divider_field = pll_control_reg0[`SCS_PLL_K2_HI:`SCS_PLL_K2_LO];

  // Active configuration, applied only at a period boundary
  reg  [1:0]    act_sel;
  reg           act_byp;
  reg           act_int;
  reg  [9:0]    act_div;
  reg  [9:0]    cnt;
  reg  [11:0]   pk_product;

  // Byte-lane merge for writes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0]  be;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i])
          merge[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
  endfunction

  // Divider field of a given configuration
  function [9:0] div_of;
    input [1:0] sel;
    input       byp;
    input [9:0] pre;
    input [6:0] k2;
    begin
      if (sel != `SCS_SEL_PLL_PRESC)
        div_of = 10'h000;
      else if (byp)
        div_of = pre;
      else
        div_of = {3'h0, k2};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  wire [4:0] pin_raw = {pll_vco_input, wakeup_clock_input, internal_clock_input,
                        crystal_input, direct_clock_input};
  reg  [4:0] pin_s1;
  reg  [4:0] pin_s2;
  reg        src_d;

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      pin_s1 <= 5'h00;
      pin_s2 <= 5'h00;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source selection and division
  reg src;
  always @* begin
    case (act_sel)
      `SCS_SEL_DIRECT:     src = pin_s2[0];
      `SCS_SEL_PLL_PRESC:  src = !act_byp ? pin_s2[4] :
                                 (act_int ? pin_s2[2] : pin_s2[1]);
      default:             src = pin_s2[3];
    endcase
  end

  wire        src_rise = src & ~src_d;
  wire [9:0]  cfg_div = div_of(clock_source_select, vco_bypass_bit,
                               prescaler_divider_field, pll_output_divider_field);
  wire        cfg_diff = (clock_source_select != act_sel) || (vco_bypass_bit != act_byp) ||
                         (pll_control_reg0[`SCS_PLL_INT_BIT] != act_int) ||
                         (cfg_div != act_div);
  wire        wrap = src_rise && (cnt == act_div);
  wire [9:0]  cnt_next = (cnt == act_div) ? 10'h000 : cnt + 10'h001;
  wire [10:0] hi_len = ({1'b0, act_div} + 11'h002) >> 1;

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      src_d         <= 1'b0;
      act_sel       <= `SCS_RST_SEL;
      act_byp       <= 1'b1;
      act_int       <= 1'b0;
      act_div       <= 10'h000;
      cnt           <= 10'h000;
      sys_clock_out <= 1'b0;
    end else begin
      src_d <= src;
      if (cfg_diff && wrap) begin
        // Hold low, take the new set; first new rising edge starts a full period
        act_sel       <= clock_source_select;
        act_byp       <= vco_bypass_bit;
        act_int       <= pll_control_reg0[`SCS_PLL_INT_BIT];
        act_div       <= cfg_div;
        cnt           <= cfg_div;
        sys_clock_out <= 1'b0;
      end else if (act_div == 10'h000) begin
        sys_clock_out <= src;
      end else if (src_rise) begin
        cnt           <= cnt_next;
        sys_clock_out <= ({1'b0, cnt_next} < hi_len);
      end
    end
  end

  // Ratio denominator (P+1)*(K2+1) for software; N is read back from its field
  always @(posedge clk_sys) begin
    if (!rst_n)
      pk_product <= 12'h000;
    else
      pk_product <= ({8'h00, pll_input_divider_field} + 12'h001) *
                    ({5'h00, pll_output_divider_field} + 12'h001);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave, one wait cycle per access
  wire        req = avs_read | avs_write;
  reg  [31:0] rd_mux;
  wire [31:0] wr_merged = merge(rd_mux, avs_writedata, avs_byteenable);
  always @* begin
    case (avs_address)
      `SCS_OFS_SYS_CTRL:   rd_mux = {30'h0, clock_source_select};
      `SCS_OFS_PLL_CTRL:   rd_mux = pll_control_reg0;
      `SCS_OFS_PRESCALER:  rd_mux = {22'h0, prescaler_divider_field};
      `SCS_OFS_FLASH_CTRL: rd_mux = {28'h0, flash_wait_state_count};
      `SCS_OFS_STATUS:     rd_mux = {4'h0, pk_product, 11'h000, sys_clock_out,
                                     cfg_diff, act_byp, act_sel};
      default:             rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      avs_waitrequest         <= 1'b1;
      avs_readdata            <= 32'h0000_0000;
      clock_source_select     <= `SCS_RST_SEL;
      pll_control_reg0        <= `SCS_RST_PLL_CTRL;
      prescaler_divider_field <= `SCS_RST_PRESCALER;
      flash_wait_state_count  <= `SCS_RST_FWS;
    end else begin
      if (req && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata    <= avs_read ? rd_mux : 32'h0000_0000;
      end else begin
        avs_waitrequest <= 1'b1;
      end
      if (avs_write && !avs_waitrequest) begin
        case (avs_address)
          `SCS_OFS_SYS_CTRL:
            clock_source_select <= wr_merged[`SCS_SYS_SEL_HI:`SCS_SYS_SEL_LO];
          `SCS_OFS_PLL_CTRL:
            pll_control_reg0 <= wr_merged & `SCS_PLL_WMASK;
          `SCS_OFS_PRESCALER:
            prescaler_divider_field <= wr_merged[`SCS_PRE_HI:`SCS_PRE_LO];
          `SCS_OFS_FLASH_CTRL:
            flash_wait_state_count <= wr_merged[`SCS_FWS_HI:`SCS_FWS_LO];
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flash fetch with wait states and one-word prefetch
  reg [1:0]    fst;
  reg [3:0]    ws_cnt;
  reg          pf_valid;
  reg [AW-1:0] pf_addr;
  reg [DW-1:0] pf_data;
  wire [3:0]   ws_load = (flash_wait_state_count == 4'h0) ? 4'h1 : flash_wait_state_count;
  wire         ws_done = (ws_cnt <= 4'h1);
  wire         take = fetch_req && !fetch_busy;

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      fst         <= ST_IDLE;
      ws_cnt      <= 4'h0;
      pf_valid    <= 1'b0;
      pf_addr     <= {AW{1'b0}};
      pf_data     <= {DW{1'b0}};
      fetch_busy  <= 1'b0;
      fetch_valid <= 1'b0;
      fetch_data  <= {DW{1'b0}};
      flash_addr  <= {AW{1'b0}};
    end else begin
      fetch_valid <= 1'b0;
      case (fst)
        ST_IDLE: begin
          if (take && pf_valid && fetch_addr == pf_addr) begin
            fetch_valid <= 1'b1;
            fetch_data  <= pf_data;
            pf_valid    <= 1'b0;
            flash_addr  <= pf_addr + 1'b1;
            ws_cnt      <= ws_load;
            fst         <= ST_PREF;
          end else if (take) begin
            pf_valid   <= 1'b0;
            flash_addr <= fetch_addr;
            ws_cnt     <= ws_load;
            fetch_busy <= 1'b1;
            fst        <= ST_DEMAND;
          end
        end
        ST_DEMAND: begin
          if (ws_done) begin
            fetch_valid <= 1'b1;
            fetch_data  <= flash_rdata;
            fetch_busy  <= 1'b0;
            flash_addr  <= flash_addr + 1'b1;
            ws_cnt      <= ws_load;
            fst         <= ST_PREF;
          end else begin
            ws_cnt <= ws_cnt - 4'h1;
          end
        end
        ST_PREF: begin
          if (take) begin
            fetch_busy <= 1'b1;
            fst        <= ST_DEMAND;
            if (fetch_addr == flash_addr) begin
              ws_cnt <= ws_done ? 4'h1 : ws_cnt - 4'h1;
            end else begin
              flash_addr <= fetch_addr;
              ws_cnt     <= ws_load;
            end
          end else if (ws_done) begin
            pf_valid <= 1'b1;
            pf_addr  <= flash_addr;
            pf_data  <= flash_rdata;
            fst      <= ST_IDLE;
          end else begin
            ws_cnt <= ws_cnt - 4'h1;
          end
        end
        default: fst <= ST_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire

// file: tb/scs_partner.sv
`default_nettype none
module scs_partner (
  input  wire logic        clk_sys,
  input  wire logic [15:0] flash_addr,
  output var  logic        direct_clock_input,
  output var  logic        crystal_input,
  output var  logic        internal_clock_input,
  output var  logic        wakeup_clock_input,
  output var  logic        pll_vco_input,
  output wire logic [31:0] flash_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] last_addr;
  // Free-running sources, edges kept off the sampling edge
  always begin
    direct_clock_input = 1'b0;
    #25 direct_clock_input = 1'b1;
    #15;
  end
  always begin
    crystal_input = 1'b0;
    #30 crystal_input = 1'b1;
    #30;
  end
  always begin
    internal_clock_input = 1'b0;
    #40 internal_clock_input = 1'b1;
    #40;
  end
  always begin
    wakeup_clock_input = 1'b0;
    #100 wakeup_clock_input = 1'b1;
    #100;
  end
  always begin
    pll_vco_input = 1'b0;
    #25 pll_vco_input = 1'b1;
    #25;
  end
  ////////////////////////////////////////
  // Array data is garbage until the address has settled
  always @(posedge clk_sys) last_addr <= flash_addr;
  assign flash_rdata = (flash_addr == last_addr) ? {flash_addr ^ 16'h5a5a, ~flash_addr}
                                                 : {~flash_addr, flash_addr ^ 16'ha5a5};
endmodule
`default_nettype wire

// file: tb/scs_checker.sv
`default_nettype none
module scs_checker #(
  parameter int AW = 16
) (
  input wire logic          clk_sys,
  input wire logic          rst_n,
  input wire logic [7:0]    avs_address,
  input wire logic          avs_read,
  input wire logic          avs_write,
  input wire logic [31:0]   avs_readdata,
  input wire logic          avs_waitrequest,
  input wire logic          sys_clock_out,
  input wire logic          fetch_req,
  input wire logic [AW-1:0] fetch_addr,
  input wire logic          fetch_busy,
  input wire logic          fetch_valid,
  input wire logic [AW-1:0] flash_addr
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] hi_cnt;
  logic [15:0] lo_cnt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      hi_cnt <= 16'h0;
      lo_cnt <= 16'h2;
    end else begin
      hi_cnt <= sys_clock_out ? hi_cnt + 16'h1 : 16'h0;
      lo_cnt <= sys_clock_out ? 16'h0 : lo_cnt + 16'h1;
    end
  end
  sequence s_bus_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_fetch_taken;
    fetch_req && !fetch_busy;
  endsequence
  ////////////////////////////////////////
  AST_WAIT_ONE: assert property (s_bus_taken |=> !avs_waitrequest)
    else $error("waitrequest not dropped after one cycle");
  AST_WAIT_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  AST_UNMAPPED: assert property (avs_read && !avs_waitrequest && avs_address > 8'h10
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  AST_MISS_BOUND: assert property (s_fetch_taken |-> ##[1:17] fetch_valid)
    else $error("fetch not answered in time");
  AST_FETCH_ADDR: assert property ($rose(fetch_busy) |-> flash_addr == $past(fetch_addr))
    else $error("flash address not the requested one");
  AST_VALID_FREE: assert property (fetch_valid |-> !fetch_busy)
    else $error("busy while delivering");
  AST_MIN_HIGH: assert property ($fell(sys_clock_out) |-> hi_cnt >= 16'h2)
    else $error("truncated high pulse");
  AST_MIN_LOW: assert property ($rose(sys_clock_out) |-> lo_cnt >= 16'h2)
    else $error("truncated low pulse");
endmodule
bind scs_clock_select scs_checker #(.AW(AW)) u_chk (
  .clk_sys, .rst_n, .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
  .sys_clock_out, .fetch_req, .fetch_addr, .fetch_busy, .fetch_valid, .flash_addr
);
`default_nettype wire

// file: tb/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  avs_address;
  logic        avs_read, avs_write, avs_waitrequest, sys_clock_out;
  logic [31:0] avs_writedata, avs_readdata, flash_rdata, fetch_data, q;
  logic [3:0]  avs_byteenable;
  logic        direct_clock_input, crystal_input, internal_clock_input;
  logic        wakeup_clock_input, pll_vco_input;
  logic        fetch_req, fetch_busy, fetch_valid;
  logic [15:0] fetch_addr, flash_addr, a;
  int          num_errors = 0, checks = 0, seed = 32'h5866, per, hi, k, kk, p, lat, mlat;
  always #2.5 clk_sys = ~clk_sys;
  scs_clock_select dut (.clk_sys, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .direct_clock_input,
    .crystal_input, .internal_clock_input, .wakeup_clock_input, .pll_vco_input,
    .sys_clock_out, .fetch_req, .fetch_addr, .fetch_busy, .fetch_valid, .fetch_data,
    .flash_addr, .flash_rdata);
  scs_partner u_far (.clk_sys, .flash_addr, .direct_clock_input, .crystal_input,
    .internal_clock_input, .wakeup_clock_input, .pll_vco_input, .flash_rdata);
  ////////////////////////////////////////
  task final_report;
    if (num_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task hang;
    num_errors++;
    final_report;
  endtask
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      num_errors++;
    end
  endtask
  function automatic logic [31:0] exp_hi(int kk, int p);
    return 32'(kk == 1 ? p / 2 : ((kk + 1) / 2) * p);
  endfunction
  task bus(input logic wr, input logic [7:0] ad, input logic [31:0] d, input logic [3:0] be);
    int n;
    @(posedge clk_sys);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= ad;
    avs_writedata <= d;
    avs_byteenable <= be;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 50) hang;
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task wr(input logic [7:0] ad, input logic [31:0] d);
    bus(1'b1, ad, d, 4'hf);
  endtask
  task rd(input string name, input logic [7:0] ad, input logic [31:0] exp);
    bus(1'b0, ad, 32'h0, 4'hf);
    check(name, q, exp);
  endtask
  // Cycles of one full output period, skipping the switch-over period
  task measure;
    int n, r;
    logic pv;
    r = 0;
    per = 0;
    hi = 0;
    pv = sys_clock_out;
    for (n = 0; n < 60000 && r < 3; n++) begin
      @(posedge clk_sys);
      if (sys_clock_out === 1'b1 && pv === 1'b0) r++;
      if (r == 2) begin
        per++;
        if (sys_clock_out === 1'b1) hi++;
      end
      pv = sys_clock_out;
    end
    if (r < 3) hang;
  endtask
  task fetch(input logic [15:0] fa);
    @(posedge clk_sys);
    fetch_req <= 1'b1;
    fetch_addr <= fa;
    for (lat = 0; lat < 40; lat++) begin
      @(posedge clk_sys);
      if (fetch_busy === 1'b0) break;
    end
    if (lat == 40) hang;
    fetch_req <= 1'b0;
    for (lat = 1; lat < 40; lat++) begin
      @(posedge clk_sys);
      if (fetch_valid === 1'b1) break;
    end
    if (lat == 40) hang;
    check("fetch_data", fetch_data, {fa ^ 16'h5a5a, ~fa});
  endtask
  ////////////////////////////////////////
  initial begin
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    fetch_req = 1'b0;
    fetch_addr = 16'h0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd("sys_ctrl", 8'h00, 32'h0);
    rd("pll_ctrl", 8'h04, 32'h1);
    rd("prescaler", 8'h08, 32'h0);
    rd("unmapped", 8'h14, 32'h0);
    measure;
    check("wakeup_period", 32'(per), 32'h28);
    wr(8'h00, 32'h3);
    measure;
    check("direct_period", 32'(per), 32'h8);
    check("direct_high", 32'(hi), 32'h3);
    for (k = 0; k < 6; k++) begin
      kk = (k < 2) ? 1 : ($random(seed) & 7) + 1;
      p = k[0] ? 16 : 12;
      wr(8'h04, {30'h0, k[0], 1'b1});
      wr(8'h08, 32'(kk - 1));
      wr(8'h00, 32'h2);
      measure;
      check("presc_period", 32'(per), 32'(kk * p));
      check("presc_high", 32'(hi), exp_hi(kk, p));
    end
    wr(8'h04, 32'h1);
    bus(1'b1, 8'h08, 32'hffff_ffff, 4'h3);
    rd("presc_max", 8'h08, 32'h3ff);
    measure;
    check("presc_max_period", 32'(per), 32'h3000);
    k = $random(seed) & 3;
    wr(8'h04, {9'h0, 7'(k), 8'h0, 4'h2, 4'h0});
    measure;
    check("pll_period", 32'(per), 32'(10 * (k + 1)));
    bus(1'b0, 8'h10, 32'h0, 4'hf);
    check("status_cfg", {16'h0, q[27:16], q[3:0]}, {16'h0, 12'(3 * (k + 1)), 4'h2});
    bus(1'b1, 8'h0c, 32'h9, 4'h0);
    rd("flash_ws", 8'h0c, 32'h4);
    wr(8'h0c, 32'h2);
    a = 16'($random(seed));
    fetch(a);
    check("miss_latency", 32'(lat), 32'h3);
    mlat = lat;
    repeat (8) @(posedge clk_sys);
    fetch(a + 16'h1);
    check("seq_faster", {31'h0, lat < mlat}, 32'h1);
    fetch(a + 16'h9);
    check("nonseq_latency", 32'(lat), 32'h3);
    final_report;
  end
endmodule
`default_nettype wire
